/* File: common/fcc_cfg.svh */
// Offsets, field positions, reset values and timing counts of the command controller
`ifndef FCC_CFG_SVH
`define FCC_CFG_SVH
`define FCC_AW 11
`define FCC_SW 2
`define FCC_DW 16
`define FCC_ARRAY_BIT 15
`define FCC_OFF_DIV 16'h0000
`define FCC_OFF_PROT 16'h0004
`define FCC_OFF_STAT 16'h0008
`define FCC_OFF_CMD 16'h000c
`define FCC_OFF_ADDR 16'h0010
`define FCC_OFF_DATA 16'h0014
`define FCC_ST_CBE 7
`define FCC_ST_CCI 6
`define FCC_ST_PVI 5
`define FCC_ST_ACC 4
`define FCC_ST_BLK 2
`define FCC_PR_OPEN 7
`define FCC_PR_HDIS 5
`define FCC_PR_LDIS 4
`define FCC_PROT_RST 8'hb0
`define FCC_CMD_VERIFY 8'h05
`define FCC_CMD_PROG 8'h20
`define FCC_CMD_SECT 8'h40
`define FCC_CMD_MASS 8'h41
`define FCC_ERASED 16'hffff
`define FCC_WORD_SEL 4'h3
`define FCC_PROG_CYC 64
`define FCC_ERASE_CYC 256
`endif

/* File: common/fcc_pkg.sv */
// Types shared by the command controller
`include "fcc_cfg.svh"
package fcc_pkg;
    typedef enum logic [1:0] {FCC_SEQ_IDLE, FCC_SEQ_ADDR, FCC_SEQ_CMD} fcc_seq_t;
    typedef enum logic [2:0] {FCC_ENG_IDLE, FCC_ENG_RUN, FCC_ENG_SWEEP, FCC_ENG_VERIFY} fcc_eng_t;
    typedef struct packed {
        logic [`FCC_AW-1:0] addr;
        logic [`FCC_DW-1:0] data;
        logic [7:0] code;
    } fcc_cmd_t;
    typedef struct packed {
        logic divld;
        logic [7:0] div;
        logic [7:0] prot;
        fcc_seq_t seq;
        fcc_cmd_t stage;
        fcc_cmd_t pend;
        logic pend_v;
        fcc_cmd_t act;
        fcc_eng_t eng;
        logic [15:0] timer;
        logic [`FCC_AW-1:0] ptr;
        logic access_error_flag;
        logic protection_violation_flag;
        logic blank;
        logic ack;
        logic [31:0] rdata;
        logic [1:0] stop_sync;
    } fcc_state_t;
endpackage

/* File: design/fcc_ctrl.sv */
// Command controller for the nonvolatile array, with Wishbone register and array access
`timescale 1ns/100ps
`include "fcc_cfg.svh"
// Overview of operation
// - Command 05 scans whole array; erased-verified flag set only if all erased.
// - Command 20 programs one 16-bit word at the captured address.
// - Command 40 erases one 1024-byte sector.
// - Command 41 erases whole array, only with all three protection bits set.
// - Verify stops at the first non-erased word, flag left clear.
// - Verify and mass erase ignore captured address and data.
// - Program stores the captured data at the captured address.
// - Sector erase uses captured address, low eleven byte-address bits and data ignored.
// - Writing 1 to buffer-empty flag launches the buffered command.
// - Protected program or sector target sets protection flag, no launch.
// - Mass erase with any protection sets protection flag, no launch.
// - Complete flag sets only when active and buffered commands are done.
// - Access error: array write before divider, byte/misaligned, or buffers full.
// - Access error: second array word, or non-command register write after word.
// - Access error: bad code, second command, or non-launch write after command.
// - Stop during a command aborts it, drops buffered one, sets access error.
// - Secured: non-mass-erase command from non-secure or debug source is error.
// - Writing 0 to buffer-empty flag aborts the sequence with access error.
// - Register reads never error; array reads while busy return invalid data.
// - Access error flag blocks any launch until cleared.
// - Protection flag blocks any launch until cleared.
// - Launch clears complete flag, then buffer-empty flag sets again.
module fcc_ctrl
    import fcc_pkg::*;
#(
    parameter int PROG_CYCLES = `FCC_PROG_CYC,
    parameter int ERASE_CYCLES = `FCC_ERASE_CYC
)(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [15:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Security context of the requester, same clock
    input wire logic secure_en,
    input wire logic nonsecure_src,
    input wire logic debug_mode,
    // Stop mode request, asynchronous
    input wire logic stop_req,
    // Status view
    output logic busy
);
    localparam int AW = `FCC_AW;
    localparam int SW = `FCC_SW;
    localparam int WORDS = 1 << AW;

    // Timer is 16 bits wide; longer waits cannot be served
    if (PROG_CYCLES < 1 || PROG_CYCLES > 65535 || ERASE_CYCLES < 1 || ERASE_CYCLES > 65535)
    begin : g_chk
        $error("fcc_ctrl: cycle counts must lie in 1..65535");
    end

    fcc_state_t s;
    fcc_state_t next_s;

    // Array storage, written only by the engine
    logic [`FCC_DW-1:0] mem [WORDS];
    logic mem_we;
    logic [AW-1:0] mem_waddr;
    logic [`FCC_DW-1:0] mem_wdata;
    logic [AW-1:0] mem_raddr;
    logic [`FCC_DW-1:0] mem_rdata;

    // Protection lookup for one target word
    function automatic logic prot_hit(input logic [AW-1:0] a, input logic [7:0] p);
        logic [SW-1:0] sec;
        sec = a[AW-1 -: SW];
        return !p[`FCC_PR_OPEN] || (sec == '0 && !p[`FCC_PR_LDIS]) ||
            (sec == '1 && !p[`FCC_PR_HDIS]);
    endfunction

    logic req;
    logic wr;
    logic arr;
    logic [AW-1:0] widx;
    logic buffer_empty_flag;
    logic command_complete_flag;
    logic locked;
    logic [7:0] stat;
    logic sweep_end;
    logic valid_code;

    // Bus decode, flag views derived from the buffers and engine, and array read port
    assign req = wb_cyc_i && wb_stb_i && !s.ack;
    assign wr = req && wb_we_i;
    assign arr = wb_adr_i[`FCC_ARRAY_BIT];
    assign widx = wb_adr_i[AW+1:2];
    assign buffer_empty_flag = !s.pend_v;
    assign command_complete_flag = (s.eng == FCC_ENG_IDLE) && !s.pend_v;
    assign locked = s.access_error_flag || s.protection_violation_flag;
    assign stat = {buffer_empty_flag, command_complete_flag, s.protection_violation_flag, s.access_error_flag, 1'b0, s.blank, 2'b00};
    assign busy = !command_complete_flag;
    assign valid_code = wb_dat_i[7:0] == `FCC_CMD_VERIFY || wb_dat_i[7:0] == `FCC_CMD_PROG ||
        wb_dat_i[7:0] == `FCC_CMD_SECT || wb_dat_i[7:0] == `FCC_CMD_MASS;
    assign sweep_end = (s.act.code == `FCC_CMD_MASS) ? (s.ptr == '1)
        : (s.ptr[AW-SW-1:0] == '1);
    assign mem_raddr = (s.eng == FCC_ENG_VERIFY) ? s.ptr : widx;
    assign mem_rdata = mem[mem_raddr];

    // Engine write port into the array
    always_comb
    begin
        mem_we = 1'b0;
        mem_waddr = s.ptr;
        mem_wdata = `FCC_ERASED;
        if (s.eng == FCC_ENG_RUN && s.timer == '0 && s.act.code == `FCC_CMD_PROG)
        begin
            mem_we = 1'b1;
            mem_waddr = s.act.addr;
            mem_wdata = s.act.data;
        end
        else if (s.eng == FCC_ENG_SWEEP)
        begin
            mem_we = 1'b1;
        end
    end

    // Next state: bus decode, command sequence, buffers and engine
    always_comb
    begin
        logic set_acc;
        logic set_pv;
        logic launch;
        logic abort;
        logic [7:0] rd;
        set_acc = 1'b0;
        set_pv = 1'b0;
        launch = 1'b0;
        abort = 1'b0;
        rd = 8'h00;
        next_s = s;
        next_s.ack = req;
        next_s.stop_sync = {s.stop_sync[0], stop_req};

        // Read data; reads never disturb the sequence
        if (req && !wb_we_i)
        begin
            if (arr)
            begin
                next_s.rdata = busy ? 32'h0000_0000 : {16'h0000, mem_rdata};
            end
            else
            begin
                unique case (wb_adr_i)
                    `FCC_OFF_DIV: rd = s.div;
                    `FCC_OFF_PROT: rd = s.prot;
                    `FCC_OFF_STAT: rd = stat;
                    `FCC_OFF_CMD: rd = s.stage.code;
                    default: rd = 8'h00;
                endcase
                next_s.rdata = {24'h000000, rd};
                if (wb_adr_i == `FCC_OFF_ADDR)
                begin
                    next_s.rdata = {{(32-AW){1'b0}}, s.stage.addr};
                end
                if (wb_adr_i == `FCC_OFF_DATA)
                begin
                    next_s.rdata = {16'h0000, s.stage.data};
                end
            end
        end

        // Array word write opens a sequence
        if (wr && arr && !locked)
        begin
            if (!s.divld || wb_sel_i != `FCC_WORD_SEL || !buffer_empty_flag)
            begin
                set_acc = 1'b1;
            end
            else if (s.seq != FCC_SEQ_IDLE)
            begin
                set_acc = 1'b1;
            end
            else
            begin
                next_s.stage.addr = widx;
                next_s.stage.data = wb_dat_i[15:0];
                next_s.seq = FCC_SEQ_ADDR;
            end
        end

        // Register writes
        if (wr && !arr)
        begin
            if (wb_adr_i == `FCC_OFF_DIV)
            begin
                next_s.div = wb_dat_i[7:0];
                next_s.divld = 1'b1;
            end
            if (wb_adr_i == `FCC_OFF_PROT)
            begin
                next_s.prot = wb_dat_i[7:0];
            end
            if (s.seq == FCC_SEQ_ADDR)
            begin
                if (wb_adr_i != `FCC_OFF_CMD)
                begin
                    set_acc = 1'b1;
                end
                else if (!valid_code)
                begin
                    set_acc = 1'b1;
                end
                else if (secure_en && (nonsecure_src || debug_mode) &&
                    wb_dat_i[7:0] != `FCC_CMD_MASS)
                begin
                    set_acc = 1'b1;
                end
                else
                begin
                    next_s.stage.code = wb_dat_i[7:0];
                    next_s.seq = FCC_SEQ_CMD;
                end
            end
            else if (s.seq == FCC_SEQ_CMD)
            begin
                if (wb_adr_i != `FCC_OFF_STAT)
                begin
                    set_acc = 1'b1;
                end
                else if (!wb_dat_i[`FCC_ST_CBE])
                begin
                    set_acc = 1'b1;
                end
                else if (!locked)
                begin
                    if (s.stage.code == `FCC_CMD_MASS)
                    begin
                        set_pv = !(s.prot[`FCC_PR_OPEN] && s.prot[`FCC_PR_HDIS] &&
                            s.prot[`FCC_PR_LDIS]);
                    end
                    else if (s.stage.code != `FCC_CMD_VERIFY)
                    begin
                        set_pv = prot_hit(s.stage.addr, s.prot);
                    end
                    launch = !set_pv;
                    next_s.seq = FCC_SEQ_IDLE;
                end
            end
        end

        // Launch moves the staged command into the waiting stage
        if (launch)
        begin
            next_s.pend = s.stage;
            next_s.pend_v = 1'b1;
        end

        // Engine
        unique case (s.eng)
            FCC_ENG_IDLE:
            begin
                if (s.pend_v)
                begin
                    next_s.act = s.pend;
                    next_s.pend_v = launch; // buffer frees once the idle engine takes the command
                    if (launch)
                    begin
                        next_s.pend = s.stage;
                    end
                    if (s.pend.code == `FCC_CMD_VERIFY)
                    begin
                        next_s.eng = FCC_ENG_VERIFY;
                        next_s.ptr = '0;
                        next_s.blank = 1'b0;
                    end
                    else
                    begin
                        next_s.eng = FCC_ENG_RUN;
                        next_s.timer = (s.pend.code == `FCC_CMD_PROG) ? 16'(PROG_CYCLES - 1)
                            : 16'(ERASE_CYCLES - 1);
                    end
                end
            end
            FCC_ENG_RUN:
            begin
                if (s.timer != '0)
                begin
                    next_s.timer = s.timer - 16'h0001;
                end
                else if (s.act.code == `FCC_CMD_PROG)
                begin
                    next_s.eng = FCC_ENG_IDLE;
                end
                else
                begin
                    next_s.eng = FCC_ENG_SWEEP;
                    // Mass erase ignores the address; sector erase keeps only its sector
                    next_s.ptr = (s.act.code == `FCC_CMD_MASS) ? '0
                        : {s.act.addr[AW-1 -: SW], {(AW-SW){1'b0}}};
                end
            end
            FCC_ENG_SWEEP:
            begin
                next_s.ptr = s.ptr + 1'b1;
                if (sweep_end)
                begin
                    next_s.eng = FCC_ENG_IDLE;
                end
            end
            FCC_ENG_VERIFY:
            begin
                next_s.ptr = s.ptr + 1'b1;
                if (mem_rdata != `FCC_ERASED)
                begin
                    next_s.eng = FCC_ENG_IDLE;
                end
                else if (s.ptr == '1)
                begin
                    next_s.blank = 1'b1;
                    next_s.eng = FCC_ENG_IDLE;
                end
            end
            default:
            begin
                next_s.eng = FCC_ENG_IDLE;
            end
        endcase

        // Stop kills both active and buffered work; high voltage must drop at once
        if (s.stop_sync[1] && busy)
        begin
            next_s.eng = FCC_ENG_IDLE;
            next_s.pend_v = 1'b0;
            set_acc = 1'b1;
        end

        abort = set_acc || set_pv;
        if (abort)
        begin
            next_s.seq = FCC_SEQ_IDLE;
        end

        // Sticky flags: write 1 clears, a new event in the same cycle wins
        if (wr && !arr && wb_adr_i == `FCC_OFF_STAT)
        begin
            if (wb_dat_i[`FCC_ST_ACC])
            begin
                next_s.access_error_flag = 1'b0;
            end
            if (wb_dat_i[`FCC_ST_PVI])
            begin
                next_s.protection_violation_flag = 1'b0;
            end
        end
        if (set_acc)
        begin
            next_s.access_error_flag = 1'b1;
        end
        if (set_pv)
        begin
            next_s.protection_violation_flag = 1'b1;
        end
    end

    // State register
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s <= '{divld: 1'b0, div: 8'h00, prot: `FCC_PROT_RST, seq: FCC_SEQ_IDLE,
                stage: '0, pend: '0, pend_v: 1'b0, act: '0, eng: FCC_ENG_IDLE,
                timer: 16'h0000, ptr: '0, access_error_flag: 1'b0, protection_violation_flag: 1'b0, blank: 1'b0,
                ack: 1'b0, rdata: 32'h0000_0000, stop_sync: 2'b00};
        end
        else
        begin
            s <= next_s;
        end
    end

    // Array write port; contents survive reset like real cells
    always_ff @(posedge clk)
    begin
        if (mem_we)
        begin
            mem[mem_waddr] <= mem_wdata;
        end
    end

    assign wb_ack_o = s.ack;
    assign wb_dat_o = s.rdata;
endmodule

/* File: tb/fcc_ctrl_assertions.sv */
// Port-level timing properties of the command controller
`timescale 1ns/100ps
`include "fcc_cfg.svh"
module fcc_ctrl_assertions #(
    parameter int PROG_CYCLES = 4,
    parameter int ERASE_CYCLES = 4
)(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [15:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // Security, stop and status
    input wire logic secure_en,
    input wire logic nonsecure_src,
    input wire logic debug_mode,
    input wire logic stop_req,
    input wire logic busy
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Decoded request kinds
    wire req = wb_cyc_i && wb_stb_i;
    wire launch = req && wb_we_i && !wb_ack_o && wb_adr_i == `FCC_OFF_STAT && wb_dat_i[`FCC_ST_CBE];
    wire rd_ack = wb_ack_o && !wb_we_i;
    sequence s_stop_held;
        (stop_req && busy) [*3];
    endsequence
    sequence s_abort;
        ##[1:3] !busy;
    endsequence
    a_ack_one_wait: assert property (req && !wb_ack_o |=> wb_ack_o) else $error("ack not one cycle after request");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
    a_ack_cause: assert property (wb_ack_o |-> $past(req)) else $error("ack without request");
    a_unmapped_zero: assert property (rd_ack && wb_adr_i == 16'h0018 |-> wb_dat_o == 32'h0)
        else $error("unmapped read not zero");
    a_stat_busy: assert property (rd_ack && wb_adr_i == `FCC_OFF_STAT && $stable(busy) |->
        wb_dat_o[`FCC_ST_CCI] != busy) else $error("complete flag disagrees with busy");
    a_busy_launch: assert property ($rose(busy) |-> $past(launch)) else $error("busy rose without launch");
    a_stop_abort: assert property (s_stop_held |-> s_abort) else $error("stop did not abort");
    a_busy_read: assert property (rd_ack && wb_adr_i[`FCC_ARRAY_BIT] && $past(busy) |->
        wb_dat_o == 32'h0) else $error("array read while busy not zero");
endmodule
bind fcc_ctrl fcc_ctrl_assertions #(.PROG_CYCLES(PROG_CYCLES), .ERASE_CYCLES(ERASE_CYCLES)) u_chk (
    .clk(clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .secure_en(secure_en), .nonsecure_src(nonsecure_src),
    .debug_mode(debug_mode), .stop_req(stop_req), .busy(busy));

/* File: tb/fcc_wb_master.sv */
// Wishbone classic master standing in for the processor
`timescale 1ns/100ps
module fcc_wb_master (
    // Clock
    input wire logic clk,
    // Request lines
    output logic cyc = 1'h0,
    output logic stb = 1'h0,
    output logic we = 1'h0,
    output logic [15:0] adr = 16'h0,
    output logic [3:0] sel = 4'h0,
    output logic [31:0] dat = 32'h0,
    // Slave answer
    input wire logic ack,
    input wire logic [31:0] rdat
);
    int gap = 0;
    // Held until ack, up to 64 cycles; released lines invert so stale data never looks valid
    task automatic xfer(input logic w, input logic [15:0] a, input logic [3:0] s,
        input logic [31:0] d, output logic [31:0] q, output bit ok);
        ok = 0;
        q = 32'h0;
        @(posedge clk);
        cyc <= 1'h1;
        stb <= 1'h1;
        we <= w;
        adr <= a;
        sel <= s;
        dat <= d;
        for (int n = 0; n < 64 && !ok; n++)
        begin
            @(posedge clk);
            ok = (ack === 1'h1);
            q = rdat;
        end
        cyc <= 1'h0;
        stb <= 1'h0;
        we <= ~w;
        adr <= ~a;
        sel <= ~s;
        dat <= ~d;
        repeat (gap) @(posedge clk);
    endtask
endmodule

/* File: tb/test_flash_command_controller.sv */
// Self-checking bench for the command controller
`timescale 1ns/100ps
`include "fcc_cfg.svh"
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin n_mismatch++; $display("[ERR] %s exp %h got %h", nm, e, g); end end
module test_flash_command_controller import fcc_pkg::*;;
    localparam logic [15:0] ST = `FCC_OFF_STAT;
    localparam logic [15:0] CM = `FCC_OFF_CMD;
    localparam logic [15:0] PR = `FCC_OFF_PROT;
    logic clk = 1'h0;
    logic rst_n = 1'h0;
    logic secure_en = 1'h0;
    logic nonsecure_src = 1'h0;
    logic debug_mode = 1'h0;
    logic stop_req = 1'h0;
    logic cyc, stb, we, ack, busy;
    logic [15:0] adr;
    logic [3:0] sel;
    logic [31:0] dat, dat_o, q;
    bit ok;
    int n_mismatch = 0;
    int compares = 0;
    // 250 MHz clock
    always #2 clk = ~clk;
    // Long program so a second command can be buffered behind it
    fcc_ctrl #(.PROG_CYCLES(64), .ERASE_CYCLES(4)) dut (.clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o),
        .wb_ack_o(ack), .secure_en(secure_en), .nonsecure_src(nonsecure_src), .debug_mode(debug_mode),
        .stop_req(stop_req), .busy(busy));
    fcc_wb_master m (.clk(clk), .cyc(cyc), .stb(stb), .we(we), .adr(adr), .sel(sel), .dat(dat),
        .ack(ack), .rdat(dat_o));
    task automatic finish_test();
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // Bus access; a lost ack ends the run
    task automatic op(input logic w, input logic [15:0] a, input logic [3:0] s, input logic [31:0] d);
        m.xfer(w, a, s, d, q, ok);
        `CHK("ack", 1'h1, ok)
        if (!ok)
            finish_test();
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        op(1'h1, a, 4'hf, {24'h0, d});
    endtask
    task automatic rd(input logic [15:0] a);
        op(1'h0, a, 4'hf, 32'h0);
    endtask
    task automatic wa(input logic [10:0] i, input logic [15:0] d, input logic [3:0] s = 4'h3);
        op(1'h1, {1'h1, 2'h0, i, 2'h0}, s, {16'h0, d});
    endtask
    task automatic rdw(input logic [10:0] i, input logic [15:0] e);
        rd({1'h1, 2'h0, i, 2'h0});
        `CHK("word", e, q[15:0])
    endtask
    task automatic cmd(input logic [10:0] i, input logic [15:0] d, input logic [7:0] c);
        wa(i, d);
        wr(CM, c);
        wr(ST, 8'h80);
    endtask
    task automatic stat(input logic [7:0] e);
        rd(ST);
        `CHK("status", e, q[7:0])
    endtask
    task automatic done();
        for (int n = 0; n < 4000 && busy !== 1'h0; n++) @(posedge clk);
        `CHK("busy", 1'h0, busy)
        if (busy !== 1'h0)
            finish_test();
    endtask
    // Main sequence; cmd keeps the array-command-launch order, the broken sequences do not
    initial
    begin
        repeat (20) @(posedge clk);
        rst_n <= 1'h1;
        stat(8'hc0);
        rd(PR);
        `CHK("prot", 8'hb0, q[7:0])
        rd(16'h0018);
        `CHK("unmapped", 32'h0, q)
        wa(11'h0, 16'h0);
        stat(8'hd0);
        cmd(11'h0, 16'h0, 8'h41);
        `CHK("busy", 1'h0, busy)
        wr(ST, 8'h00);
        stat(8'hd0);
        wr(ST, 8'h30);
        stat(8'hc0);
        wr(16'h0, 8'h01);
        wa(11'h0, 16'h0, 4'h1);
        stat(8'hd0);
        wr(ST, 8'h30);
        cmd(11'h5, 16'h1234, 8'h41);
        `CHK("busy", 1'h1, busy)
        done();
        cmd(11'h7, 16'h0, 8'h05);
        done();
        stat(8'hc4);
        m.gap = 2;
        cmd(11'h210, 16'ha5c3, 8'h20);
        stat(8'h84);
        rdw(11'h210, 16'h0);
        // Captured buffer and divider read back while the program runs
        rd(16'h0010);
        `CHK("addr", 32'h0000_0210, q)
        rd(16'h0014);
        `CHK("data", 32'h0000_a5c3, q)
        rd(CM);
        `CHK("code", 8'h20, q[7:0])
        rd(16'h0000);
        `CHK("div", 8'h01, q[7:0])
        cmd(11'h400, 16'h5aa5, 8'h20);
        stat(8'h04);
        done();
        m.gap = 0;
        rdw(11'h210, 16'ha5c3);
        rdw(11'h400, 16'h5aa5);
        cmd(11'h0, 16'h0, 8'h05);
        done();
        stat(8'hc0);
        cmd(11'h3ff, 16'h1357, 8'h40);
        done();
        rdw(11'h210, 16'hffff);
        rdw(11'h400, 16'h5aa5);
        wr(PR, 8'h80);
        cmd(11'h010, 16'h0, 8'h20);
        stat(8'he0);
        cmd(11'h400, 16'h0, 8'h40);
        `CHK("busy", 1'h0, busy)
        wr(ST, 8'h30);
        cmd(11'h400, 16'h0, 8'h41);
        stat(8'he0);
        wr(ST, 8'h30);
        wr(PR, 8'hb0);
        // Broken sequences, each aborted with an access error
        for (int i = 0; i < 6; i++)
        begin
            wa(11'h1, 16'h0);
            case (i)
                0: wa(11'h2, 16'h0);
                1: wr(PR, 8'hb0);
                2: wr(CM, 8'h33);
                3: wr(CM, 8'h20);
                4: wr(ST, 8'h00);
                default: wr(CM, 8'h40);
            endcase
            if (i == 3)
                wr(CM, 8'h20);
            if (i == 5)
                wr(16'h0, 8'h01);
            stat(8'hd0);
            wr(ST, 8'h30);
        end
        // Secured requester: only mass erase passes
        for (int j = 0; j < 2; j++)
        begin
            secure_en <= 1'h1;
            nonsecure_src <= (j == 0);
            debug_mode <= (j == 1);
            cmd(11'h1, 16'h0, 8'h20);
            stat(8'hd0);
            wr(ST, 8'h30);
        end
        cmd(11'h0, 16'h0, 8'h41);
        `CHK("busy", 1'h1, busy)
        secure_en <= 1'h0;
        cmd(11'h020, 16'h0, 8'h20);
        stop_req <= 1'h1;
        repeat (6) @(posedge clk);
        `CHK("busy", 1'h0, busy)
        stop_req <= 1'h0;
        repeat (10) @(posedge clk);
        `CHK("busy", 1'h0, busy)
        stat(8'hd0);
        finish_test();
    end
endmodule
